// ==== testbench/tso_sink.sv ====
// downstream stream consumer model: samples the forwarded stream on its sampling edge
// assumes the bench hands it the polarity settings and the serial or parallel format
`timescale 1ns/100ps
module tso_sink
(
	input wire logic       clk,
	input wire logic       arm,
	input wire logic       watch,
	input wire logic       ser,
	input wire logic [3:0] inv,
	input wire logic       stream_clock_out,
	input wire logic [7:0] parallel_byte_out,
	input wire logic       serial_bit_out,
	input wire logic       packet_start_flag,
	input wire logic       packet_valid_strobe,
	input wire logic       packet_error_flag
);
	logic [7:0]  q_data[$];
	logic [2:0]  q_flag[$];
	int          q_gap[$];
	int          gap      = 0;
	int          bad_edge = 0;
	logic        started  = 1'b0;
	logic        sclk_d   = 1'b0;
	logic [11:0] outs_d   = 12'h000;
	wire  [11:0] outs;
	wire  [2:0]  flags;
	wire         edge_seen;
	wire         smp;
	wire         launch;

	// ****************************************
	// edge and polarity decoding
	// ****************************************
	assign outs      = {parallel_byte_out, serial_bit_out, packet_start_flag, packet_valid_strobe, packet_error_flag};
	assign flags     = {packet_start_flag ^ inv[1], packet_valid_strobe ^ inv[2], packet_error_flag ^ inv[3]};
	assign edge_seen = sclk_d != stream_clock_out;
	assign smp       = edge_seen && (stream_clock_out != inv[0]);
	assign launch    = edge_seen && (stream_clock_out == inv[0]);

	// ****************************************
	// capture of units from the first start on
	// ****************************************
	always @(posedge clk)
	begin
		if (watch && outs != outs_d && !launch)
			bad_edge++;
		if (!arm)
		begin
			q_data.delete();
			q_flag.delete();
			q_gap.delete();
			started = 1'b0;
		end
		else if (smp && (started || flags[2]))
		begin
			started = 1'b1;
			q_data.push_back(ser ? {7'h00, serial_bit_out} : parallel_byte_out);
			q_flag.push_back(flags);
			q_gap.push_back(gap);
		end
		gap    = smp ? 1 : gap + 1;
		sclk_d = stream_clock_out;
		outs_d = outs;
	end
endmodule

// ==== testbench/tso_top_test.sv ====
// self-checking bench of the transport stream output formatter
// assumes tso_cfg.svh on the include path and the sink model compiled before it
`timescale 1ns/100ps
`include "tso_cfg.svh"
module tso_top_test;
	logic        clk       = 1'b0;
	logic        rst       = 1'b1;
	logic [3:0]  reg_addr  = 4'h0;
	logic [31:0] reg_wdata = 32'h0;
	logic        reg_wr    = 1'b0;
	logic        reg_rd    = 1'b0;
	logic [31:0] reg_rdata;
	logic [7:0]  in_data   = 8'h00;
	logic        in_first  = 1'b0;
	logic        in_error  = 1'b0;
	logic        in_valid  = 1'b0;
	logic        in_ready;
	logic        stream_clock_out;
	logic [7:0]  parallel_byte_out;
	logic        serial_bit_out;
	logic        packet_start_flag;
	logic        packet_valid_strobe;
	logic        packet_error_flag;
	logic        arm       = 1'b0;
	logic        watch     = 1'b0;
	logic        ser       = 1'b0;
	logic [3:0]  inv       = 4'h0;
	int          n_fail    = 0;
	int          checks    = 0;

	tso_top uut
	(
		.clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.in_data, .in_first, .in_error, .in_valid, .in_ready,
		.stream_clock_out, .parallel_byte_out, .serial_bit_out,
		.packet_start_flag, .packet_valid_strobe, .packet_error_flag
	);

	tso_sink sink
	(
		.clk, .arm, .watch, .ser, .inv,
		.stream_clock_out, .parallel_byte_out, .serial_bit_out,
		.packet_start_flag, .packet_valid_strobe, .packet_error_flag
	);

	initial
	begin
		forever #2 clk = ~clk;
	end

	// ****************************************
	// shared tasks
	// ****************************************
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic end_of_test;
		if (n_fail == 0 && checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge clk);
		reg_wr    <= 1'b0;
		@(posedge clk);
	endtask

	task automatic reg_read(input logic [3:0] a, output logic [31:0] d);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge clk);
		reg_rd   <= 1'b0;
		@(negedge clk);
		d = reg_rdata;
		@(posedge clk);
	endtask

	// one packet upstream, each byte held until taken
	task automatic feed(input int n, input logic err, input logic [7:0] seed);
		int w;
		for (int i = 0; i < n; i++)
		begin
			in_data  <= 8'(i) ^ seed;
			in_first <= (i == 0);
			in_error <= err;
			in_valid <= 1'b1;
			w = 0;
			@(negedge clk);
			while (in_ready !== 1'b1 && w < 4000)
			begin
				@(negedge clk);
				w++;
			end
			check(in_ready, 1'b1);
			@(posedge clk);
		end
		in_valid <= 1'b0;
		in_first <= 1'b0;
	endtask

	// configure, send one packet, judge every sampled unit
	task automatic run(input logic [31:0] ctrl, input int nred, input int f10, input logic err);
		int         step;
		int         units;
		int         lo;
		int         w;
		logic [7:0] b;
		step  = ctrl[1] ? 8 : 1;
		units = (188 + nred) * step;
		lo    = 25000000 / f10;
		b     = 8'h00;
		ser   <= ctrl[1];
		inv   <= ctrl[11:8];
		arm   <= 1'b0;
		reg_write(`TSO_ADDR_CTRL, ctrl);
		repeat (4) @(posedge clk);
		arm   <= 1'b1;
		watch <= 1'b1;
		feed(188 + nred, err, ctrl[7:0]);
		w = 0;
		while (sink.q_data.size() <= units && w < 30000)
		begin
			@(posedge clk);
			w++;
		end
		watch <= 1'b0;
		check(sink.q_data.size() > units, 1'b1);
		for (int k = 0; k < units; k++)
		begin
			check(sink.q_flag[k], {k < step, k < 188 * step, err});
			if (k > 0)
				check(sink.q_gap[k] >= lo && sink.q_gap[k] <= lo + 1, 1'b1);
			b = ctrl[1] ? {b[6:0], sink.q_data[k][0]} : sink.q_data[k];
			if (k % step == step - 1)
				check(b, 8'(k / step) ^ ctrl[7:0]);
		end
		check(sink.q_flag[units][2:1], 2'b00);
	endtask

	// ****************************************
	// scenarios
	// ****************************************
	task automatic s_regs;
		logic [31:0] d;
		reg_read(`TSO_ADDR_CTRL, d);
		check(d, `TSO_CTRL_RESET);
		reg_read(`TSO_ADDR_STATUS, d);
		check(d, 32'h0);
		reg_write(`TSO_ADDR_CTRL, 32'hffff_ffff);
		reg_read(`TSO_ADDR_CTRL, d);
		check(d, `TSO_CTRL_MASK);
		reg_write(4'hc, 32'hffff_ffff);
		reg_read(4'hc, d);
		check(d, 32'h0);
		reg_write(`TSO_ADDR_CTRL, 32'h0);
	endtask

	// parallel data-only, vsb, packet flagged bad
	task automatic s_par_vsb;
		run(32'h0000_0001, 0, int'(`TSO_F_PAR_VSB), 1'b1);
	endtask

	// serial data-only, 256-qam, clean packet
	task automatic s_ser_q256;
		run(32'h0000_0013, 0, int'(`TSO_F_SER_Q256), 1'b0);
	endtask

	// parallel with redundancy, 64-qam, every polarity inverted
	task automatic s_par_red_q64_inv;
		run(32'h0000_0f0d, int'(`TSO_RED_QAM), int'(`TSO_F_RED_Q64), 1'b1);
	endtask

	// serial with redundancy, vsb
	task automatic s_ser_red_vsb;
		run(32'h0000_0007, int'(`TSO_RED_VSB), int'(`TSO_F_RED_VSB * `TSO_SER_RED_MUL), 1'b0);
	endtask

	task automatic s_count;
		logic [31:0] d;
		reg_read(`TSO_ADDR_COUNT, d);
		check(d, 32'h4);
		reg_read(`TSO_ADDR_STATUS, d);
		check(d[1], 1'b0);
		check(32'(sink.bad_edge), 32'h0);
	endtask

	// ****************************************
	// main sequence and watchdog
	// ****************************************
	initial
	begin
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		s_regs();
		s_par_vsb();
		s_ser_q256();
		s_par_red_q64_inv();
		s_ser_red_vsb();
		s_count();
		end_of_test();
	end

	initial
	begin
		#400000;
		n_fail++;
		end_of_test();
	end
endmodule

// ==== verilog/tso_cfg.svh ====
// constants of the transport stream output formatter: offsets, fields, resets, rates
// assumes a 250 MHz core clock and a 4-bit word-aligned register port
`ifndef TSO_CFG_SVH
`define TSO_CFG_SVH

// ****************************************
// register map
// ****************************************
`define TSO_ADDR_CTRL      4'h0
`define TSO_ADDR_STATUS    4'h4
`define TSO_ADDR_COUNT     4'h8
`define TSO_CTRL_RESET     32'h0000_0000
`define TSO_CTRL_MASK      32'h0000_0f1f
`define TSO_CTRL_EN        0
`define TSO_CTRL_SER       1
`define TSO_CTRL_RED       2
`define TSO_CTRL_MOD_LO    3
`define TSO_CTRL_MOD_HI    4
`define TSO_CTRL_CLK_INV   8
`define TSO_CTRL_START_INV 9
`define TSO_CTRL_VALID_INV 10
`define TSO_CTRL_ERR_INV   11
`define TSO_STAT_BUSY      0
`define TSO_STAT_UNDERRUN  1

// ****************************************
// packet shape
// ****************************************
`define TSO_PKT_BYTES      8'hbc
`define TSO_RED_VSB        8'h14
`define TSO_RED_QAM        8'h10
`define TSO_BIT_TOP        3'h7

// ****************************************
// rates, in units of 10 Hz
// ****************************************
`define TSO_CLK_10HZ       64'd25000000
`define TSO_F_PAR_VSB      64'd242408
`define TSO_F_PAR_Q64      64'd337129
`define TSO_F_PAR_Q256     64'd485133
`define TSO_F_SER_VSB      64'd1939266
`define TSO_F_SER_Q64      64'd2697035
`define TSO_F_SER_Q256     64'd3881070
`define TSO_F_RED_VSB      64'd268196
`define TSO_F_RED_Q64      64'd365821
`define TSO_F_RED_Q256     64'd526422
`define TSO_SER_RED_MUL    64'h8

`endif

// ==== verilog/tso_clk_if.sv ====
// link between the formatter core and its stream clock generator
// assumes both ends run on the same core clock
`timescale 1ns/100ps
interface tso_clk_if;
	logic [31:0] inc;
	logic        run;
	logic        inv;
	logic        launch;
	logic        stream_clk;

	modport gen  (input inc, input run, input inv, output launch, output stream_clk);
	modport user (output inc, output run, output inv, input launch, input stream_clk);
endinterface

// ==== verilog/tso_clkgen.sv ====
// fractional divider making the forwarded stream clock from the core clock
// assumes inc = 2 * f_stream * 2^32 / f_core, nonzero while run is high
`timescale 1ns/100ps
module tso_clkgen
	import tso_pkg::*;
(
	input  wire logic clk,
	input  wire logic rst,
	tso_clk_if.gen    cif
);
`include "tso_cfg.svh"

	logic [31:0] acc_reg;
	logic [31:0] acc_next;
	logic        phase_reg;
	logic        phase_next;
	logic        clk_out_reg;
	wire  [32:0] acc_sum_w = {1'b0, acc_reg} + {1'b0, cif.inc};
	wire         toggle_w  = cif.run & acc_sum_w[32];

	// ****************************************
	// half-period ticks, launch on falling phase
	// ****************************************
	assign acc_next       = cif.run ? acc_sum_w[31:0] : 32'h0000_0000;
	assign phase_next     = cif.run ? (phase_reg ^ toggle_w) : 1'b0;
	assign cif.launch     = toggle_w & phase_reg;
	assign cif.stream_clk = clk_out_reg;

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			acc_reg     <= 32'h0000_0000;
			phase_reg   <= 1'b0;
			clk_out_reg <= 1'b0;
		end
		else
		begin
			acc_reg     <= acc_next;
			phase_reg   <= phase_next;
			clk_out_reg <= phase_next ^ cif.inv;
		end
	end

	// ****************************************
	// checks
	// ****************************************
	logic [15:0] hp_cnt_reg;
	logic        hp_ok_reg;
	logic [31:0] inc_q_reg;
	wire  [32:0] hp_len_w   = {17'h0_0000, hp_cnt_reg} + 33'h0_0000_0001;
	wire  [32:0] half_min_w = 33'h1_0000_0000 / {1'b0, (cif.inc == 32'h0000_0000) ? 32'h0000_0001 : cif.inc};

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			hp_cnt_reg <= 16'h0000;
			hp_ok_reg  <= 1'b0;
			inc_q_reg  <= 32'h0000_0000;
		end
		else
		begin
			inc_q_reg <= cif.inc;
			if (!cif.run || (cif.inc != inc_q_reg))
			begin
				hp_cnt_reg <= 16'h0000;
				hp_ok_reg  <= 1'b0;
			end
			else if (toggle_w)
			begin
				hp_cnt_reg <= 16'h0000;
				hp_ok_reg  <= 1'b1;
			end
			else
				hp_cnt_reg <= hp_cnt_reg + 16'h0001;
		end
	end

	property p_half_period;
		@(posedge clk) disable iff (rst)
		toggle_w && hp_ok_reg && (cif.inc == inc_q_reg) |-> (hp_len_w >= half_min_w) && (hp_len_w <= half_min_w + 33'h0_0000_0001);
	endproperty
	a_half_period: assert property (p_half_period) else $error("stream clock half period off rate");

endmodule

// ==== verilog/tso_pkg.sv ====
// types of the transport stream output formatter
// assumes tso_cfg.svh for all numeric constants
package tso_pkg;

	typedef enum logic [1:0] {TSO_MOD_VSB, TSO_MOD_QAM64, TSO_MOD_QAM256, TSO_MOD_RSVD} tso_mod_t;

	typedef enum logic {TSO_IDLE, TSO_SEND} tso_state_t;

endpackage

// ==== verilog/tso_top.sv ====
// transport stream output formatter: 188-byte packets out in parallel or serial form
// assumes upstream bytes on the core clock, packet start marked on the first byte
//
// The plain strobed port and the register addresses were decided locally.
`timescale 1ns/100ps
module tso_top
	import tso_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic [3:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [31:0] reg_rdata,
	input  wire logic [7:0]  in_data,
	input  wire logic        in_first,
	input  wire logic        in_error,
	input  wire logic        in_valid,
	output logic             in_ready,
	output logic             stream_clock_out,
	output logic      [7:0]  parallel_byte_out,
	output logic             serial_bit_out,
	output logic             packet_start_flag,
	output logic             packet_valid_strobe,
	output logic             packet_error_flag
);
`include "tso_cfg.svh"

	// ****************************************
	// decode helpers
	// ****************************************
	function automatic logic tso_is_qam(input tso_mod_t m);
		tso_is_qam = (m != TSO_MOD_VSB);
	endfunction

	function automatic logic [7:0] tso_red_len(input logic qam);
		tso_red_len = qam ? `TSO_RED_QAM : `TSO_RED_VSB;
	endfunction

	function automatic logic [31:0] tso_inc(input logic [63:0] f);
		logic [63:0] q;
		q = ((f * 64'h2) << 32) / `TSO_CLK_10HZ;
		tso_inc = q[31:0];
	endfunction

	function automatic logic [31:0] tso_inc_sel(input logic ser, input logic red, input tso_mod_t m);
		logic [63:0] f;
		f = `TSO_F_PAR_Q256;
		case ({ser, red})
			2'b00:   f = (m == TSO_MOD_VSB) ? `TSO_F_PAR_VSB : (m == TSO_MOD_QAM64) ? `TSO_F_PAR_Q64 : `TSO_F_PAR_Q256;
			2'b10:   f = (m == TSO_MOD_VSB) ? `TSO_F_SER_VSB : (m == TSO_MOD_QAM64) ? `TSO_F_SER_Q64 : `TSO_F_SER_Q256;
			2'b01:   f = (m == TSO_MOD_VSB) ? `TSO_F_RED_VSB : (m == TSO_MOD_QAM64) ? `TSO_F_RED_Q64 : `TSO_F_RED_Q256;
			default: f = `TSO_SER_RED_MUL * ((m == TSO_MOD_VSB) ? `TSO_F_RED_VSB
				: (m == TSO_MOD_QAM64) ? `TSO_F_RED_Q64 : `TSO_F_RED_Q256);
		endcase
		tso_inc_sel = tso_inc(f);
	endfunction

	// ****************************************
	// state
	// ****************************************
	tso_clk_if clk_if();

	logic [31:0] ctrl_reg;
	logic [31:0] rdata_reg;
	tso_state_t  state_reg,     state_next;
	logic [7:0]  byte_idx_reg,  byte_idx_next;
	logic [2:0]  bit_idx_reg,   bit_idx_next;
	logic [7:0]  byte_reg,      byte_next;
	logic        pkt_ser_reg,   pkt_ser_next;
	logic        pkt_red_reg,   pkt_red_next;
	logic        pkt_qam_reg,   pkt_qam_next;
	logic        start_act_reg, start_act_next;
	logic        valid_act_reg, valid_act_next;
	logic        err_act_reg,   err_act_next;
	logic        underrun_reg;
	logic [15:0] pkt_cnt_reg;
	logic [7:0]  par_out_reg;
	logic        ser_out_reg;
	logic        start_out_reg;
	logic        valid_out_reg;
	logic        err_out_reg;

	wire       en_w        = ctrl_reg[`TSO_CTRL_EN];
	wire       ser_w       = ctrl_reg[`TSO_CTRL_SER];
	wire       red_w       = ctrl_reg[`TSO_CTRL_RED];
	tso_mod_t  mod_w;
	wire       start_inv_w = ctrl_reg[`TSO_CTRL_START_INV];
	wire       valid_inv_w = ctrl_reg[`TSO_CTRL_VALID_INV];
	wire       err_inv_w   = ctrl_reg[`TSO_CTRL_ERR_INV];
	wire       launch_w    = clk_if.launch;
	wire       sending_w   = (state_reg == TSO_SEND);
	wire       boundary_w  = sending_w && (!pkt_ser_reg || (bit_idx_reg == 3'h0));
	wire [7:0] pkt_last_w  = `TSO_PKT_BYTES - 8'h01 + (pkt_red_reg ? tso_red_len(pkt_qam_reg) : 8'h00);
	wire       last_w      = (byte_idx_reg == pkt_last_w);
	wire       need_byte_w = !sending_w || boundary_w;
	wire       need_st_w   = !sending_w || (boundary_w && last_w);
	wire       start_now_w = launch_w && en_w && need_st_w && in_valid && in_first;
	wire       mid_take_w  = launch_w && en_w && boundary_w && !last_w;
	wire [7:0] mid_byte_w  = in_valid ? in_data : 8'h00;
	wire [7:0] idx_inc_w   = byte_idx_reg + 8'h01;

	assign mod_w = tso_mod_t'(ctrl_reg[`TSO_CTRL_MOD_HI:`TSO_CTRL_MOD_LO]);

	// ****************************************
	// stream clock
	// ****************************************
	assign clk_if.inc = tso_inc_sel(ser_w, red_w, mod_w);
	assign clk_if.run = en_w;
	assign clk_if.inv = ctrl_reg[`TSO_CTRL_CLK_INV];

	tso_clkgen u_clkgen
	(
		.clk (clk),
		.rst (rst),
		.cif (clk_if)
	);

	// ****************************************
	// packet sequencer
	// ****************************************
	assign in_ready = launch_w && en_w && need_byte_w;

	always_comb
	begin
		state_next     = state_reg;
		byte_idx_next  = byte_idx_reg;
		bit_idx_next   = bit_idx_reg;
		byte_next      = byte_reg;
		pkt_ser_next   = pkt_ser_reg;
		pkt_red_next   = pkt_red_reg;
		pkt_qam_next   = pkt_qam_reg;
		start_act_next = start_act_reg;
		valid_act_next = valid_act_reg;
		err_act_next   = err_act_reg;
		if (!en_w)
		begin
			state_next     = TSO_IDLE;
			start_act_next = 1'b0;
			valid_act_next = 1'b0;
			err_act_next   = 1'b0;
		end
		else if (launch_w)
		begin
			if (start_now_w)
			begin
				state_next     = TSO_SEND;
				byte_idx_next  = 8'h00;
				bit_idx_next   = `TSO_BIT_TOP;
				byte_next      = in_data;
				pkt_ser_next   = ser_w;
				pkt_red_next   = red_w;
				pkt_qam_next   = tso_is_qam(mod_w);
				start_act_next = 1'b1;
				valid_act_next = 1'b1;
				err_act_next   = in_error;
			end
			else if (mid_take_w)
			begin
				byte_idx_next  = idx_inc_w;
				bit_idx_next   = `TSO_BIT_TOP;
				byte_next      = mid_byte_w;
				start_act_next = 1'b0;
				valid_act_next = !pkt_red_reg || (idx_inc_w < `TSO_PKT_BYTES);
			end
			else if (sending_w && !boundary_w)
				bit_idx_next = bit_idx_reg - 3'h1;
			else
			begin
				state_next     = TSO_IDLE;
				byte_next      = 8'h00;
				start_act_next = 1'b0;
				valid_act_next = 1'b0;
				err_act_next   = 1'b0;
			end
		end
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			state_reg     <= TSO_IDLE;
			byte_idx_reg  <= 8'h00;
			bit_idx_reg   <= 3'h0;
			byte_reg      <= 8'h00;
			pkt_ser_reg   <= 1'b0;
			pkt_red_reg   <= 1'b0;
			pkt_qam_reg   <= 1'b0;
			start_act_reg <= 1'b0;
			valid_act_reg <= 1'b0;
			err_act_reg   <= 1'b0;
		end
		else
		begin
			state_reg     <= state_next;
			byte_idx_reg  <= byte_idx_next;
			bit_idx_reg   <= bit_idx_next;
			byte_reg      <= byte_next;
			pkt_ser_reg   <= pkt_ser_next;
			pkt_red_reg   <= pkt_red_next;
			pkt_qam_reg   <= pkt_qam_next;
			start_act_reg <= start_act_next;
			valid_act_reg <= valid_act_next;
			err_act_reg   <= err_act_next;
		end
	end

	// ****************************************
	// output pins, polarity applied in the flop
	// ****************************************
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			par_out_reg   <= 8'h00;
			ser_out_reg   <= 1'b0;
			start_out_reg <= 1'b0;
			valid_out_reg <= 1'b0;
			err_out_reg   <= 1'b0;
		end
		else
		begin
			par_out_reg   <= pkt_ser_next ? 8'h00 : byte_next;
			ser_out_reg   <= pkt_ser_next && byte_next[bit_idx_next];
			start_out_reg <= start_act_next ^ start_inv_w;
			valid_out_reg <= valid_act_next ^ valid_inv_w;
			err_out_reg   <= err_act_next ^ err_inv_w;
		end
	end

	assign stream_clock_out    = clk_if.stream_clk;
	assign parallel_byte_out   = par_out_reg;
	assign serial_bit_out      = ser_out_reg;
	assign packet_start_flag   = start_out_reg;
	assign packet_valid_strobe = valid_out_reg;
	assign packet_error_flag   = err_out_reg;

	// ****************************************
	// register port
	// ****************************************
	wire wr_ctrl_w = reg_wr && (reg_addr == `TSO_ADDR_CTRL);
	wire clr_ur_w  = reg_wr && (reg_addr == `TSO_ADDR_STATUS) && reg_wdata[`TSO_STAT_UNDERRUN];
	wire set_ur_w  = mid_take_w && !in_valid;
	wire [31:0] rd_mux_w = (reg_addr == `TSO_ADDR_CTRL) ? ctrl_reg
		: (reg_addr == `TSO_ADDR_STATUS) ? {16'h0000, byte_idx_reg, 6'h00, underrun_reg, sending_w}
		: (reg_addr == `TSO_ADDR_COUNT) ? {16'h0000, pkt_cnt_reg}
		: 32'h0000_0000;

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			ctrl_reg     <= `TSO_CTRL_RESET;
			rdata_reg    <= 32'h0000_0000;
			underrun_reg <= 1'b0;
			pkt_cnt_reg  <= 16'h0000;
		end
		else
		begin
			if (wr_ctrl_w)
				ctrl_reg <= reg_wdata & `TSO_CTRL_MASK;
			rdata_reg    <= reg_rd ? rd_mux_w : 32'h0000_0000;
			// a new underrun beats a clear in the same cycle
			underrun_reg <= set_ur_w || (underrun_reg && !clr_ur_w);
			if (start_now_w)
				pkt_cnt_reg <= pkt_cnt_reg + 16'h0001;
		end
	end

	assign reg_rdata = rdata_reg;

	// ****************************************
	// checks
	// ****************************************
	logic [3:0] start_len_reg;

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			start_len_reg <= 4'h0;
		else if (launch_w)
			start_len_reg <= start_act_next ? start_len_reg + 4'h1 : 4'h0;
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	property p_polarity;
		$stable(ctrl_reg) |-> {packet_start_flag, packet_valid_strobe, packet_error_flag}
			== {start_act_reg ^ start_inv_w, valid_act_reg ^ valid_inv_w, err_act_reg ^ err_inv_w};
	endproperty
	a_polarity: assert property (p_polarity) else $error("flag polarity mismatch");

	property p_launch_edge;
		$changed(parallel_byte_out) && $stable(ctrl_reg) |-> $past(launch_w) && (stream_clock_out == clk_if.inv);
	endproperty
	a_launch_edge: assert property (p_launch_edge) else $error("data moved off the launch edge");

	property p_pkt_len;
		(($fell(sending_w) || ($rose(start_act_reg) && $past(sending_w))) && $past(en_w) && !$past(pkt_red_reg))
			|-> $past(byte_idx_reg) == 8'hbb;
	endproperty
	a_pkt_len: assert property (p_pkt_len) else $error("packet not 188 bytes");

	property p_par_byte;
		$past(mid_take_w) && !pkt_ser_reg |-> parallel_byte_out == $past(mid_byte_w);
	endproperty
	a_par_byte: assert property (p_par_byte) else $error("parallel byte not presented");

	property p_ser_start;
		$fell(start_act_reg) && $past(launch_w && en_w && pkt_ser_reg) |-> $past(start_len_reg) == 4'h8;
	endproperty
	a_ser_start: assert property (p_ser_start) else $error("serial start not eight clocks");

	property p_par_start;
		$fell(start_act_reg) && $past(launch_w && en_w && !pkt_ser_reg) |-> $past(start_len_reg) == 4'h1;
	endproperty
	a_par_start: assert property (p_par_start) else $error("parallel start not one clock");

	property p_valid_cont;
		en_w && sending_w && !pkt_red_reg |-> valid_act_reg;
	endproperty
	a_valid_cont: assert property (p_valid_cont) else $error("valid dropped in data-only packet");

	property p_valid_red;
		sending_w && pkt_red_reg |-> valid_act_reg == (byte_idx_reg < 8'hbc);
	endproperty
	a_valid_red: assert property (p_valid_red) else $error("valid wrong around redundancy");

	property p_red_len;
		(($fell(sending_w) || ($rose(start_act_reg) && $past(sending_w))) && $past(en_w) && $past(pkt_red_reg))
			|-> $past(byte_idx_reg) == ($past(pkt_qam_reg) ? 8'hcb : 8'hcf);
	endproperty
	a_red_len: assert property (p_red_len) else $error("wrong redundancy byte count");

	property p_err_hold;
		$past(sending_w) && sending_w && !$rose(start_act_reg) |-> $stable(err_act_reg);
	endproperty
	a_err_hold: assert property (p_err_hold) else $error("error flag changed inside packet");

	c_par_pkt: cover property ($rose(start_act_reg) && !pkt_ser_reg);
	c_ser_pkt: cover property ($rose(start_act_reg) && pkt_ser_reg);
	c_err_pkt: cover property ($rose(err_act_reg));
	c_red_gap: cover property ($fell(valid_act_reg) && sending_w && pkt_red_reg);

endmodule
